// *** gtw_pkg.sv ***
// Constants and types shared by the two-wire host controller files.
// Assumes a 200 MHz reference clock; all counts derive from it.
package gtw_pkg;
  localparam int CLK_MHZ = 200;
  // Fastest serial clock the target accepts
  localparam int SCL_MAX_KHZ = 400;
  localparam int SCL_PERIOD_NS = 1000000 / SCL_MAX_KHZ;
  // Quarter of a bit, rounded up so the rate never exceeds the limit
  localparam int QTR_CYC = (SCL_PERIOD_NS * CLK_MHZ / 1000 + 3) / 4;
  localparam int QTR_W = 8;
  localparam logic [QTR_W-1:0] QTR_LAST = QTR_W'(QTR_CYC - 1);

  // External timebase on the clock-or-restart pin
  localparam int EXT_CLK_HZ = 32768;
  localparam int EO_W = 12;
  localparam int EXT_HALF_CYC = CLK_MHZ * 1000000 / (2 * EXT_CLK_HZ);
  localparam logic [EO_W-1:0] EXT_HALF_LAST = EO_W'(EXT_HALF_CYC - 1);
  // High time of a hardware quick-start pulse
  localparam int QS_PULSE_US = 10;
  localparam int QS_HIGH_CYC = QS_PULSE_US * CLK_MHZ;
  localparam logic [EO_W-1:0] QS_HIGH_LAST = EO_W'(QS_HIGH_CYC - 1);

  localparam logic [6:0] TARGET_ADDR = 7'h36;
  localparam logic DIR_WR = 1'b0;
  localparam logic DIR_RD = 1'b1;

  // Quarter phases of one serial bit
  localparam logic [1:0] PH_LOW = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_HIGH = 2'h2;
  localparam logic [1:0] PH_FALL = 2'h3;
  localparam logic [3:0] ACK_BIT = 4'h8;

  // Byte positions within a transaction
  localparam logic [2:0] STEP_ADDR = 3'h0;
  localparam logic [2:0] STEP_PTR = 3'h1;
  localparam logic [2:0] STEP_HI = 3'h2;
  localparam logic [2:0] STEP_LO = 3'h3;
  localparam logic [2:0] STEP_RD_LO = 3'h4;

  localparam logic [1:0] MAX_RETRY = 2'h3;

  typedef enum logic [1:0] {CMD_PROBE, CMD_WRITE, CMD_READ} gtw_cmd_e;
endpackage

// *** gtw_ctl_if.sv ***
// Internal signals between the host controller and its helper modules.
// Assumes all parties run on the same reference clock.
`timescale 1ns/1ps
`default_nettype none
interface gtw_ctl_if;
  logic en;
  logic run;
  logic tick;
  logic ext_mode;
  logic qs_req;
  logic eo_lvl;
  modport top (output en, output run, output ext_mode, output qs_req,
               input tick, input eo_lvl);
  modport tick_gen (input en, input run, output tick);
  modport osc (input en, input ext_mode, input qs_req, output eo_lvl);
endinterface
`default_nettype wire

// *** gtw_qtr_tick.sv ***
// Quarter-bit timebase for the serial clock.
// Assumes run is held high for the whole of a transaction.
`timescale 1ns/1ps
`default_nettype none
module gtw_qtr_tick (
  input wire logic clk_in,
  input wire logic rst_n_in,
  gtw_ctl_if.tick_gen ctl
);
  import gtw_pkg::*;

  logic [QTR_W-1:0] cnt_q;
  logic tick_q;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= '0;
    end else if (ctl.en) begin
      if (!ctl.run || cnt_q == QTR_LAST) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_q <= 1'b0;
    end else if (ctl.en) begin
      tick_q <= ctl.run && cnt_q == QTR_LAST;
    end
  end

  assign ctl.tick = tick_q;
endmodule
`default_nettype wire

// *** gtw_eo_drive.sv ***
// Drives the clock-or-restart level: a divided 32 kHz clock in external
// mode, otherwise a single high pulse per quick-start request.
// Assumes qs_req is a one-cycle pulse on the reference clock.
`timescale 1ns/1ps
`default_nettype none
module gtw_eo_drive (
  input wire logic clk_in,
  input wire logic rst_n_in,
  gtw_ctl_if.osc ctl
);
  import gtw_pkg::*;

  logic [EO_W-1:0] cnt_q;
  logic lvl_q;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= '0;
      lvl_q <= 1'b0;
    end else if (ctl.en) begin
      if (ctl.ext_mode) begin
        if (cnt_q == EXT_HALF_LAST) begin
          cnt_q <= '0;
          lvl_q <= ~lvl_q;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end else if (ctl.qs_req && !lvl_q) begin
        cnt_q <= '0;
        lvl_q <= 1'b1;
      end else if (lvl_q) begin
        if (cnt_q >= QS_HIGH_LAST) begin
          cnt_q <= '0;
          lvl_q <= 1'b0;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end else begin
        cnt_q <= '0;
      end
    end
  end

  assign ctl.eo_lvl = lvl_q;
endmodule
`default_nettype wire

// *** gtw_host.sv ***
// Two-wire bus master for a fuel-gauge target: probe, 16-bit register
// write and 16-bit register read, plus oscillator and restart pins.
// Assumes a pull-up on the data line and a single master on the bus.
`timescale 1ns/1ps
`default_nettype none
module gtw_host (
  input wire logic REF_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CE_IN,
  input wire logic CMD_VALID_IN,
  output logic CMD_READY_OUT,
  input wire gtw_pkg::gtw_cmd_e CMD_KIND_IN,
  input wire logic [7:0] CMD_PTR_IN,
  input wire logic [15:0] CMD_WDATA_IN,
  output logic DONE_OUT,
  output logic NACK_OUT,
  output logic [15:0] RD_DATA_OUT,
  output logic SCL_OUT,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_OUT,
  input wire logic EXT_CLK_MODE_IN,
  input wire logic QSTART_IN,
  output logic OSC_SEL_OUT,
  output logic EO_OUT
);
  import gtw_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_BYTE, ST_STOP, ST_END
  } gtw_state_e;

  gtw_state_e st_q;
  gtw_cmd_e cmd_q;
  logic [7:0] ptr_q;
  logic [15:0] wdata_q;
  logic [2:0] step_q;
  logic [3:0] bit_q;
  logic [1:0] ph_q;
  logic [7:0] sh_q;
  logic [15:0] rd_q;
  logic [1:0] retry_q;
  logic nack_q;
  logic scl_q;
  logic sda_oe_q;
  logic sda_m_q;
  logic sda_s_q;
  logic ready_q;
  logic done_q;
  logic nack_out_q;
  logic [15:0] rd_out_q;
  logic osc_sel_q;
  logic eo_q;
  logic tick;
  logic rx_now;
  logic last_now;

  gtw_ctl_if ctl ();

  assign ctl.en = CE_IN;
  assign ctl.run = st_q != ST_IDLE && st_q != ST_END;
  assign ctl.ext_mode = EXT_CLK_MODE_IN;
  assign ctl.qs_req = QSTART_IN && !EXT_CLK_MODE_IN;
  assign tick = ctl.tick;

  gtw_qtr_tick u_tick (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RST_N_IN),
    .ctl(ctl.tick_gen)
  );

  gtw_eo_drive u_eo (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RST_N_IN),
    .ctl(ctl.osc)
  );

  // Byte sent at each step of a transaction
  function automatic logic [7:0] tx_byte(input gtw_cmd_e cmd,
                                         input logic [2:0] step,
                                         input logic [7:0] ptr,
                                         input logic [15:0] wd);
    tx_byte = {TARGET_ADDR, DIR_WR};
    if (step == STEP_PTR) begin
      tx_byte = ptr;
    end else if (step == STEP_HI) begin
      tx_byte = (cmd == CMD_READ) ? {TARGET_ADDR, DIR_RD} : wd[15:8];
    end else if (step == STEP_LO) begin
      tx_byte = wd[7:0];
    end
  endfunction

  function automatic logic is_rx(input gtw_cmd_e cmd,
                                 input logic [2:0] step);
    is_rx = cmd == CMD_READ && step >= STEP_LO;
  endfunction

  function automatic logic [2:0] last_step(input gtw_cmd_e cmd);
    last_step = STEP_ADDR;
    if (cmd == CMD_WRITE) begin
      last_step = STEP_LO;
    end else if (cmd == CMD_READ) begin
      last_step = STEP_RD_LO;
    end
  endfunction

  assign rx_now = is_rx(cmd_q, step_q);
  assign last_now = step_q == last_step(cmd_q);

  // Data line synchroniser
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
    end else if (CE_IN) begin
      sda_m_q <= SDA_IN;
      sda_s_q <= sda_m_q;
    end
  end

  // Transaction sequencer
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st_q <= ST_IDLE;
      cmd_q <= CMD_PROBE;
      ptr_q <= '0;
      wdata_q <= '0;
      step_q <= STEP_ADDR;
      bit_q <= '0;
      ph_q <= PH_LOW;
      sh_q <= '0;
      retry_q <= '0;
      nack_q <= 1'b0;
    end else if (CE_IN) begin
      case (st_q)
        ST_IDLE: begin
          if (CMD_VALID_IN) begin
            cmd_q <= CMD_KIND_IN;
            ptr_q <= CMD_PTR_IN;
            wdata_q <= CMD_WDATA_IN;
            step_q <= STEP_ADDR;
            retry_q <= '0;
            nack_q <= 1'b0;
            ph_q <= PH_LOW;
            st_q <= ST_START;
          end
        end
        ST_START: begin
          if (tick) begin
            ph_q <= ph_q + 1'b1;
            if (ph_q == PH_FALL) begin
              bit_q <= '0;
              sh_q <= tx_byte(cmd_q, step_q, ptr_q, wdata_q);
              st_q <= ST_BYTE;
            end
          end
        end
        ST_BYTE: begin
          if (tick) begin
            ph_q <= ph_q + 1'b1;
            if (ph_q == PH_HIGH && bit_q == ACK_BIT && !rx_now &&
                sda_s_q) begin
              nack_q <= 1'b1;
            end
            if (ph_q == PH_FALL) begin
              if (bit_q != ACK_BIT) begin
                bit_q <= bit_q + 1'b1;
                sh_q <= {sh_q[6:0], 1'b0};
              end else if (nack_q || last_now) begin
                st_q <= ST_STOP;
              end else if (cmd_q == CMD_READ && step_q == STEP_PTR) begin
                step_q <= STEP_HI;
                st_q <= ST_START;
              end else begin
                step_q <= step_q + 1'b1;
                bit_q <= '0;
                sh_q <= tx_byte(cmd_q, step_q + 3'h1, ptr_q, wdata_q);
              end
            end
          end
        end
        ST_STOP: begin
          if (tick) begin
            ph_q <= ph_q + 1'b1;
            if (ph_q == PH_FALL) begin
              st_q <= ST_END;
            end
          end
        end
        ST_END: begin
          if (nack_q && cmd_q != CMD_PROBE && retry_q < MAX_RETRY) begin
            retry_q <= retry_q + 1'b1;
            nack_q <= 1'b0;
            step_q <= STEP_ADDR;
            ph_q <= PH_LOW;
            st_q <= ST_START;
          end else begin
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Serial clock, made by the host only
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      scl_q <= 1'b1;
    end else if (CE_IN && tick) begin
      if (ph_q == PH_RISE) begin
        scl_q <= 1'b1;
      end else if (ph_q == PH_FALL && st_q != ST_STOP) begin
        scl_q <= 1'b0;
      end
    end
  end

  // Data line pull-down, changed while the clock is low except for START and STOP, which change it while the clock is high
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      sda_oe_q <= 1'b0;
    end else if (CE_IN && tick) begin
      case (st_q)
        ST_START: begin
          if (ph_q == PH_LOW) begin
            sda_oe_q <= 1'b0;
          end else if (ph_q == PH_HIGH) begin
            sda_oe_q <= 1'b1;
          end
        end
        ST_BYTE: begin
          if (ph_q == PH_LOW) begin
            if (bit_q != ACK_BIT) begin
              sda_oe_q <= !rx_now && !sh_q[7];
            end else begin
              // Acknowledge all but last read byte
              sda_oe_q <= rx_now && !last_now;
            end
          end
        end
        ST_STOP: begin
          if (ph_q == PH_LOW) begin
            sda_oe_q <= 1'b1;
          end else if (ph_q == PH_HIGH) begin
            sda_oe_q <= 1'b0;
          end
        end
        default: begin
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // Read word gathered high byte first
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rd_q <= '0;
    end else if (CE_IN && tick && st_q == ST_BYTE) begin
      if (ph_q == PH_HIGH && rx_now && bit_q != ACK_BIT) begin
        rd_q <= {rd_q[14:0], sda_s_q};
      end
    end
  end

  // Command port answers
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ready_q <= 1'b1;
      done_q <= 1'b0;
      nack_out_q <= 1'b0;
      rd_out_q <= '0;
    end else if (CE_IN) begin
      done_q <= 1'b0;
      if (st_q == ST_IDLE && CMD_VALID_IN) begin
        ready_q <= 1'b0;
      end else if (st_q == ST_END &&
                   !(nack_q && cmd_q != CMD_PROBE &&
                     retry_q < MAX_RETRY)) begin
        ready_q <= 1'b1;
        done_q <= 1'b1;
        nack_out_q <= nack_q;
        if (cmd_q == CMD_READ && !nack_q) begin
          rd_out_q <= rd_q;
        end
      end
    end
  end

  // Oscillator select and clock-or-restart pin
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      osc_sel_q <= 1'b0;
      eo_q <= 1'b0;
    end else if (CE_IN) begin
      osc_sel_q <= EXT_CLK_MODE_IN;
      eo_q <= ctl.eo_lvl;
    end
  end

  assign CMD_READY_OUT = ready_q;
  assign DONE_OUT = done_q;
  assign NACK_OUT = nack_out_q;
  assign RD_DATA_OUT = rd_out_q;
  assign SCL_OUT = scl_q;
  assign SDA_OUT = 1'b0;
  assign SDA_OE_OUT = sda_oe_q;
  assign OSC_SEL_OUT = osc_sel_q;
  assign EO_OUT = eo_q;

  // Checks
  localparam int SCL_HI_MIN = 2 * QTR_CYC;
  logic [QTR_W:0] hi_cnt_q;

  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      hi_cnt_q <= '0;
    end else if (CE_IN) begin
      if (!scl_q) begin
        hi_cnt_q <= '0;
      end else if (hi_cnt_q != '1) begin
        hi_cnt_q <= hi_cnt_q + 1'b1;
      end
    end
  end

  a_idle_lines: assert property (@(posedge REF_CLK_IN)
    disable iff (!RST_N_IN) st_q == ST_IDLE |-> scl_q && !sda_oe_q)
    else $error("bus not released while idle");

  a_scl_high_len: assert property (@(posedge REF_CLK_IN)
    disable iff (!RST_N_IN)
    $fell(scl_q) |-> $past(hi_cnt_q) >= (QTR_W+1)'(SCL_HI_MIN - 1))
    else $error("serial clock high time too short");

  a_data_steady: assert property (@(posedge REF_CLK_IN)
    disable iff (!RST_N_IN)
    st_q == ST_BYTE && $past(st_q) == ST_BYTE && scl_q && $past(scl_q)
    |-> $stable(sda_oe_q))
    else $error("data changed while clock high");

  a_start_only: assert property (@(posedge REF_CLK_IN)
    disable iff (!RST_N_IN)
    $rose(sda_oe_q) && $past(scl_q) |-> st_q == ST_START)
    else $error("data fell at high clock outside START");

  a_stop_only: assert property (@(posedge REF_CLK_IN)
    disable iff (!RST_N_IN)
    $fell(sda_oe_q) && $past(scl_q) |-> st_q == ST_STOP ##1 scl_q)
    else $error("data rose at high clock outside STOP");

  a_restart_read: assert property (@(posedge REF_CLK_IN)
    disable iff (!RST_N_IN)
    st_q == ST_START && step_q == STEP_HI |-> cmd_q == CMD_READ)
    else $error("repeated START outside a read");

  a_bit_advance: assert property (@(posedge REF_CLK_IN)
    disable iff (!RST_N_IN)
    tick && st_q == ST_BYTE && ph_q == PH_FALL && bit_q != ACK_BIT
    |=> bit_q == $past(bit_q) + 4'h1)
    else $error("bit counter skipped");

  a_master_ack: assert property (@(posedge REF_CLK_IN)
    disable iff (!RST_N_IN)
    st_q == ST_BYTE && rx_now && bit_q == ACK_BIT && scl_q
    |-> sda_oe_q == !last_now)
    else $error("wrong host acknowledge on read byte");

  a_slave_ack_free: assert property (@(posedge REF_CLK_IN)
    disable iff (!RST_N_IN)
    st_q == ST_BYTE && !rx_now && bit_q == ACK_BIT && scl_q |-> !sda_oe_q)
    else $error("host held data during target acknowledge");

  a_dir_bit: assert property (@(posedge REF_CLK_IN)
    disable iff (!RST_N_IN)
    st_q == ST_BYTE && step_q == STEP_ADDR && bit_q == 4'h7 && scl_q
    |-> sda_oe_q)
    else $error("first address byte not a write");

  a_retry_bound: assert property (@(posedge REF_CLK_IN)
    disable iff (!RST_N_IN)
    st_q == ST_END && nack_q && retry_q == MAX_RETRY |=> st_q == ST_IDLE)
    else $error("retries not bounded");
endmodule
`default_nettype wire

// *** gtw_tgt_model.sv ***
// Behavioural fuel-gauge target on the two-wire bus and its two pins.
// Assumes the bench resolves the pulled-up data line from both enables.
`timescale 1ns/1ps
`default_nettype none
module gtw_tgt_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic nak_in,
  input wire logic osc_sel_in,
  input wire logic eo_in,
  output logic sda_oe_out,
  output int starts_out,
  output int qs_out
);
  logic [7:0] mem [256];
  logic [2:0] scl_q, sda_q;
  logic [7:0] rx_q, tx_q, hi_q;
  logic [8:0] ptr_q;
  logic [3:0] bit_q;
  int idx_q;
  logic act_q, rd_q, txon_q, mack_q, eo_q;
  wire logic hi_w = scl_q[1] & scl_q[2];
  wire logic start_w = hi_w & sda_q[2] & ~sda_q[1];
  wire logic stop_w = hi_w & ~sda_q[2] & sda_q[1];
  wire logic rise_w = scl_q[1] & ~scl_q[2];
  wire logic fall_w = ~scl_q[1] & scl_q[2];

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i);
    end
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
      eo_q <= 1'b0;
      act_q <= 1'b0;
      sda_oe_out <= 1'b0;
      starts_out <= 0;
      qs_out <= 0;
    end else begin
      scl_q <= {scl_q[1:0], scl_in};
      sda_q <= {sda_q[1:0], sda_in};
      eo_q <= eo_in;
      // Restart edge only on internal timebase
      if (!osc_sel_in && eo_in && !eo_q) begin
        qs_out <= qs_out + 1;
      end
      if (start_w) begin
        act_q <= 1'b1;
        // Clock fall that closes START carries no bit
        bit_q <= 4'hF;
        idx_q <= 0;
        txon_q <= 1'b0;
        sda_oe_out <= 1'b0;
        starts_out <= starts_out + 1;
      end else if (stop_w) begin
        act_q <= 1'b0;
        sda_oe_out <= 1'b0;
      end else if (act_q && rise_w) begin
        // Sample MSB first while clock high
        if (bit_q < 4'h8) begin
          rx_q <= {rx_q[6:0], sda_q[1]};
        end else begin
          mack_q <= ~sda_q[1];
        end
      end else if (act_q && fall_w && bit_q == 4'h7) begin
        bit_q <= 4'h8;
        sda_oe_out <= ~txon_q;
        if (txon_q) begin
        end else if (idx_q == 0) begin
          rd_q <= rx_q[0];
          if (rx_q[7:1] != 7'h36 || nak_in) begin
            sda_oe_out <= 1'b0;
            act_q <= 1'b0;
          end
        end else if (idx_q == 1) begin
          ptr_q <= {1'b0, rx_q};
        end else begin
          // Word commits with its low byte
          if (!ptr_q[0]) begin
            hi_q <= rx_q;
          end else if (!ptr_q[8]) begin
            mem[ptr_q[7:0] - 8'h01] <= hi_q;
            mem[ptr_q[7:0]] <= rx_q;
          end
          ptr_q <= ptr_q + 9'h001;
        end
      end else if (act_q && fall_w && bit_q == 4'h8) begin
        bit_q <= 4'h0;
        idx_q <= idx_q + 1;
        sda_oe_out <= 1'b0;
        txon_q <= 1'b0;
        // Next byte, FFh past the top
        if (rd_q && (idx_q == 0 || (txon_q && mack_q))) begin
          tx_q <= ptr_q[8] ? 8'hFF : mem[ptr_q[7:0]];
          sda_oe_out <= ptr_q[8] ? 1'b0 : ~mem[ptr_q[7:0]][7];
          txon_q <= 1'b1;
          ptr_q <= ptr_q + 9'h001;
        end
      end else if (act_q && fall_w) begin
        bit_q <= bit_q + 4'h1;
        // Data moves only while clock low
        if (txon_q) begin
          sda_oe_out <= ~tx_q[6];
          tx_q <= {tx_q[6:0], 1'b0};
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** gtw_tb.sv ***
// Self-checking bench: two-wire host against the target model.
// Assumes model memory starts with each byte equal to its address.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin \
  fails++; $display("unexpected %s expected %0h seen %0h", nm, ex, gt); \
  end end
module tb;
  import gtw_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic valid = 1'b0;
  logic ext = 1'b0;
  logic qs = 1'b0;
  logic nak = 1'b0;
  logic ce = 1'b1;
  gtw_cmd_e kind = CMD_PROBE;
  logic [7:0] ptr = 8'h00;
  logic [15:0] wd = 16'h0000;
  logic ready, done, nack, scl, sda_o, sda_oe, osc_sel, eo, tgt_oe;
  logic [15:0] rd;
  logic scl_p = 1'b1;
  int starts, qsn;
  int fails = 0;
  int checks = 0;
  int gap = 1000;
  wire logic sda = ~((sda_oe & ~sda_o) | tgt_oe);

  always #2.5 clk = ~clk;

  gtw_host dut (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce),
    .CMD_VALID_IN(valid), .CMD_READY_OUT(ready), .CMD_KIND_IN(kind),
    .CMD_PTR_IN(ptr), .CMD_WDATA_IN(wd), .DONE_OUT(done),
    .NACK_OUT(nack), .RD_DATA_OUT(rd), .SCL_OUT(scl), .SDA_IN(sda),
    .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe), .EXT_CLK_MODE_IN(ext),
    .QSTART_IN(qs), .OSC_SEL_OUT(osc_sel), .EO_OUT(eo));
  gtw_tgt_model tgt (.clk_in(clk), .rst_n_in(rst_n), .scl_in(scl),
    .sda_in(sda), .nak_in(nak), .osc_sel_in(osc_sel), .eo_in(eo),
    .sda_oe_out(tgt_oe), .starts_out(starts), .qs_out(qsn));

  always @(posedge clk) begin
    scl_p <= scl;
    if (scl === 1'b1 && scl_p === 1'b0) begin
      gap <= 0;
      checks++;
      if (gap < 499) begin
        fails++;
        $display("unexpected scl_gap expected 499 seen %0d", gap);
      end
    end else begin
      gap <= gap + 1;
    end
  end

  task automatic final_report;
    if (fails == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic run_cmd(input gtw_cmd_e k, input logic [7:0] p,
                         input logic [15:0] w);
    int n;
    n = 0;
    kind = k;
    ptr = p;
    wd = w;
    valid = 1'b1;
    step(1);
    valid = 1'b0;
    while (done !== 1'b1 && n < 40000) begin
      step(1);
      n++;
    end
    if (n >= 40000) begin
      fails++;
      final_report();
    end
  endtask

  task automatic wait_eo(input logic lvl, input int lim, output int n);
    n = 0;
    while (eo !== lvl && n < lim) begin
      step(1);
      n++;
    end
    if (n >= lim) begin
      fails++;
      final_report();
    end
  endtask

  task automatic t_reset;
    step(1);
    `CHK("ready", 1'b1, ready)
    `CHK("scl", 1'b1, scl)
    `CHK("sda_oe", 1'b0, sda_oe)
    `CHK("sda_o", 1'b0, sda_o)
    `CHK("done", 1'b0, done)
    `CHK("nack", 1'b0, nack)
    `CHK("rd", 16'h0000, rd)
    `CHK("osc_sel", 1'b0, osc_sel)
    `CHK("eo", 1'b0, eo)
  endtask

  task automatic t_probe;
    run_cmd(CMD_PROBE, 8'h00, 16'h0000);
    `CHK("probe_nack", 1'b0, nack)
    `CHK("probe_starts", 1, starts)
    nak = 1'b1;
    run_cmd(CMD_PROBE, 8'h00, 16'h0000);
    nak = 1'b0;
    `CHK("probe_nak", 1'b1, nack)
    `CHK("probe_no_retry", 2, starts)
  endtask

  task automatic t_write_read;
    int s0;
    run_cmd(CMD_WRITE, 8'hFE, 16'hABCD);
    `CHK("wr_nack", 1'b0, nack)
    `CHK("mem_even", 8'hAB, tgt.mem[8'hFE])
    `CHK("mem_odd", 8'hCD, tgt.mem[8'hFF])
    s0 = starts;
    run_cmd(CMD_READ, 8'hFF, 16'h0000);
    `CHK("rd_nack", 1'b0, nack)
    `CHK("rd_data", 16'hCDFF, rd)
    `CHK("rd_restart", s0 + 2, starts)
  endtask

  task automatic t_retry;
    int s0;
    s0 = starts;
    nak = 1'b1;
    run_cmd(CMD_WRITE, 8'h10, 16'h5AA5);
    nak = 1'b0;
    `CHK("retry_nack", 1'b1, nack)
    `CHK("retry_count", s0 + 1 + int'(MAX_RETRY), starts)
    `CHK("retry_mem", 8'h10, tgt.mem[8'h10])
  endtask

  task automatic t_osc;
    int n;
    int s0;
    ext = 1'b1;
    step(2);
    `CHK("osc_sel", 1'b1, osc_sel)
    wait_eo(1'b0, 4000, n);
    wait_eo(1'b1, 4000, n);
    wait_eo(1'b0, 4000, n);
    `CHK("ext_half", EXT_HALF_CYC, n)
    // Clock enable low must hold the timebase still
    ce = 1'b0;
    step(3100);
    `CHK("eo_frozen", 1'b0, eo)
    ce = 1'b1;
    s0 = qsn;
    qs = 1'b1;
    step(1);
    qs = 1'b0;
    step(10);
    `CHK("qs_in_ext", s0, qsn)
    ext = 1'b0;
    wait_eo(1'b0, 4000, n);
    step(2);
    s0 = qsn;
    qs = 1'b1;
    step(1);
    qs = 1'b0;
    wait_eo(1'b1, 100, n);
    wait_eo(1'b0, 3000, n);
    `CHK("qs_high", QS_HIGH_CYC, n)
    `CHK("qs_count", s0 + 1, qsn)
  endtask

  initial begin
    step(10);
    rst_n = 1'b1;
    t_reset();
    t_probe();
    t_write_read();
    t_retry();
    t_osc();
    final_report();
  end
endmodule
`undef CHK
`default_nettype wire
